//--- design/isaas_pkg.sv
package isaas_pkg;

	// ==========================================================
	// Port mode field encodings
	localparam logic [3:0] MODE_SLAVE7    = 4'h6;
	localparam logic [3:0] MODE_SLAVE10   = 4'h7;
	localparam logic [3:0] MODE_MASK_ACC  = 4'h9;
	localparam logic [3:0] MODE_FW_MASTER = 4'hb;
	localparam logic [3:0] MODE_SLAVE7_SP  = 4'he;
	localparam logic [3:0] MODE_SLAVE10_SP = 4'hf;

	// ==========================================================
	// Reset values and address patterns
	localparam logic [7:0] ADDR_RST      = 8'h00;
	localparam logic [7:0] MASK_RST      = 8'hff;
	localparam logic [7:0] BYTE_ZERO     = 8'h00;
	localparam logic [4:0] TEN_BIT_HDR   = 5'h1e;

	// ==========================================================
	// Bit counting
	localparam logic [3:0] CNT_ZERO      = 4'h0;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic [3:0] LAST_TX_CNT   = 4'h7;
	localparam logic [2:0] MSB_INDEX     = 3'h7;

	// ==========================================================
	// Address phases after a start
	localparam logic [1:0] PH_ADDR    = 2'h0;
	localparam logic [1:0] PH_ADDR_LO = 2'h1;
	localparam logic [1:0] PH_DATA    = 2'h2;

	// ==========================================================
	// Engine states
	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_RX   = 5'h02,
		ST_ACK  = 5'h04,
		ST_TX   = 5'h08,
		ST_MACK = 5'h10
	} isaas_state_e;

endpackage

//--- design/isaas_top.sv
`timescale 1ns/1ps
// Functional notes
// - Valid byte received: drive acknowledge and copy shift register into buffer
// - Buffer full, overflow or firmware master: no ack, no load, irq still set
// - Buffer read clears full flag; overflow only cleared by software
// - After enable wait for start, shift eight bits on rising SCL
// - Seven-bit mode compares shift bits 7:1 with address at eighth fall
// - Match with flags clear: load, set full, ack; irq at ninth fall
// - Ten-bit high byte is 11110, A9, A8, direction write
// - Each ten-bit write address byte sets irq, full, update flag, holds SCL
// - Ten-bit read after repeated start sets full, clears release bit
// - Mask register writable only while mode field is 1001
// - Mask zero bits ignored in compare; mask resets to all ones
// - Matched write address loaded to buffer; overflow if unread
// - Irq per data byte; status via full, direction, data flags
// - Read match sets direction flag, acks, then holds SCL low
// - Software write sets full; SCL released only by release bit
// - Transmit: full cleared at eighth fall, irq at ninth fall
// - After eighth fall release SDA; nack ends, ack stretches again
// - Stretch after ten-bit address and hardware release clear
// - Overflow set when a byte completes with buffer still full
// - Start is SDA fall with SCL high, stop is SDA rise
// - Pull SCL low only after sampling it low
module isaas_top (
	// Clock and reset
	input  wire logic       MCLK_I,
	input  wire logic       NRST_I,
	// Bus pins
	input  wire logic       SCL_I,
	output logic            SCL_O,
	output logic            SCL_OEN_O,
	input  wire logic       SDA_I,
	output logic            SDA_O,
	output logic            SDA_OEN_O,
	// Software control
	input  wire logic       ENABLE_I,
	input  wire logic [3:0] MODE_I,
	input  wire logic       ADDR_WR_I,
	input  wire logic [7:0] ADDR_WDATA_I,
	input  wire logic       MASK_WR_I,
	input  wire logic [7:0] MASK_WDATA_I,
	input  wire logic       BUF_RD_I,
	input  wire logic       BUF_WR_I,
	input  wire logic [7:0] BUF_WDATA_I,
	input  wire logic       OVF_CLR_I,
	input  wire logic       IRQ_CLR_I,
	input  wire logic       CKP_SET_I,
	// Status
	output logic [7:0]      BUF_DATA_O,
	output logic            BUF_FULL_O,
	output logic            OVERFLOW_O,
	output logic            IRQ_FLAG_O,
	output logic            ADDR_UPDATE_O,
	output logic            READ_WRITE_O,
	output logic            DATA_NOT_ADDR_O,
	output logic            CLK_RELEASE_O,
	output logic            START_O,
	output logic            STOP_O,
	output logic [7:0]      SLAVE_ADDR_O,
	output logic [7:0]      ADDR_MASK_O
);

	// ==========================================================
	// Pin synchronisers and edge detection
	logic scl_s1_reg, scl_s2_reg, scl_d_reg;
	logic sda_s1_reg, sda_s2_reg, sda_d_reg;
	logic scl_rise, scl_fall, start_det, stop_det;

	// Idle bus level is high, so reset to one to avoid a false start
	always_ff @(posedge MCLK_I) begin
		if (!NRST_I) begin
			scl_s1_reg <= 1'b1;
			scl_s2_reg <= 1'b1;
			scl_d_reg  <= 1'b1;
			sda_s1_reg <= 1'b1;
			sda_s2_reg <= 1'b1;
			sda_d_reg  <= 1'b1;
		end else begin
			scl_s1_reg <= SCL_I;
			scl_s2_reg <= scl_s1_reg;
			scl_d_reg  <= scl_s2_reg;
			sda_s1_reg <= SDA_I;
			sda_s2_reg <= sda_s1_reg;
			sda_d_reg  <= sda_s2_reg;
		end
	end

	assign scl_rise  = scl_s2_reg & ~scl_d_reg;
	assign scl_fall  = ~scl_s2_reg & scl_d_reg;
	assign start_det = scl_s2_reg & scl_d_reg & sda_d_reg & ~sda_s2_reg;
	assign stop_det  = scl_s2_reg & scl_d_reg & ~sda_d_reg & sda_s2_reg;

	// ==========================================================
	// Registers
	isaas_pkg::isaas_state_e state_reg;
	logic [3:0] cnt_reg;
	logic [7:0] shift_reg, buf_reg, addr_reg, mask_reg, mask_vis_reg;
	logic [1:0] phase_reg;
	logic       addr10_ok_reg, take_reg, ack_reg, ua_pend_reg, tx_pend_reg;
	logic       stay_reg, nack_reg;
	logic       bf_reg, ovf_reg, irq_reg, ua_reg, rw_reg, da_reg, ckp_reg;
	logic       start_reg, stop_reg, scl_oen_reg, sda_oen_reg, low_reg;

	// ==========================================================
	// Mode decode and byte evaluation
	logic       fw_master, slave7, slave10, sp_irq;
	logic       match7, match_hi, match_lo;
	logic       take_now, is_addr_now, tx_now, stay_now, ua_now, addr10_now;
	logic       ack_now, rx_done, rx_load, ack_fall, tx_byte_end, mack_fall;
	logic [1:0] phase_next;

	assign fw_master = MODE_I == isaas_pkg::MODE_FW_MASTER;
	assign slave7    = MODE_I == isaas_pkg::MODE_SLAVE7 || MODE_I == isaas_pkg::MODE_SLAVE7_SP;
	assign slave10   = MODE_I == isaas_pkg::MODE_SLAVE10 || MODE_I == isaas_pkg::MODE_SLAVE10_SP;
	assign sp_irq    = fw_master || MODE_I == isaas_pkg::MODE_SLAVE7_SP
		|| MODE_I == isaas_pkg::MODE_SLAVE10_SP;

	assign match7   = ((shift_reg[7:1] ^ addr_reg[7:1]) & mask_reg[7:1]) == 7'h00;
	assign match_hi = shift_reg[7:3] == isaas_pkg::TEN_BIT_HDR
		&& shift_reg[2:1] == addr_reg[2:1];
	assign match_lo = ((shift_reg ^ addr_reg) & mask_reg) == isaas_pkg::BYTE_ZERO;

	always_comb begin
		take_now    = 1'b0;
		is_addr_now = 1'b0;
		tx_now      = 1'b0;
		stay_now    = 1'b0;
		ua_now      = 1'b0;
		addr10_now  = addr10_ok_reg;
		phase_next  = phase_reg;
		case (phase_reg)
			isaas_pkg::PH_ADDR: begin
				if (fw_master) begin
					take_now = 1'b1;
					stay_now = 1'b1;
				end else if (slave7 && match7) begin
					take_now    = 1'b1;
					is_addr_now = 1'b1;
					tx_now      = shift_reg[0];
					stay_now    = ~shift_reg[0];
					phase_next  = isaas_pkg::PH_DATA;
				end else if (slave10 && match_hi && !shift_reg[0]) begin
					take_now    = 1'b1;
					is_addr_now = 1'b1;
					ua_now      = 1'b1;
					stay_now    = 1'b1;
					phase_next  = isaas_pkg::PH_ADDR_LO;
				end else if (slave10 && match_hi && addr10_ok_reg) begin
					take_now    = 1'b1;
					is_addr_now = 1'b1;
					tx_now      = 1'b1;
				end
			end
			isaas_pkg::PH_ADDR_LO: begin
				if (match_lo) begin
					take_now    = 1'b1;
					is_addr_now = 1'b1;
					ua_now      = 1'b1;
					stay_now    = 1'b1;
					addr10_now  = 1'b1;
					phase_next  = isaas_pkg::PH_DATA;
				end
			end
			default: begin
				take_now = 1'b1;
				stay_now = 1'b1;
			end
		endcase
	end

	assign ack_now     = take_now & ~bf_reg & ~ovf_reg & ~fw_master;
	assign rx_done     = state_reg == isaas_pkg::ST_RX && scl_fall
		&& cnt_reg == isaas_pkg::BITS_PER_BYTE;
	assign rx_load     = rx_done & ack_now;
	assign ack_fall    = state_reg == isaas_pkg::ST_ACK && scl_fall;
	assign tx_byte_end = state_reg == isaas_pkg::ST_TX && scl_fall
		&& cnt_reg == isaas_pkg::LAST_TX_CNT;
	assign mack_fall   = state_reg == isaas_pkg::ST_MACK && scl_fall;

	// ==========================================================
	// Transfer sequencer
	always_ff @(posedge MCLK_I) begin
		if (!NRST_I || !ENABLE_I) begin
			state_reg     <= isaas_pkg::ST_IDLE;
			cnt_reg       <= isaas_pkg::CNT_ZERO;
			shift_reg     <= isaas_pkg::BYTE_ZERO;
			phase_reg     <= isaas_pkg::PH_ADDR;
			addr10_ok_reg <= 1'b0;
			take_reg      <= 1'b0;
			ack_reg       <= 1'b0;
			ua_pend_reg   <= 1'b0;
			tx_pend_reg   <= 1'b0;
			stay_reg      <= 1'b0;
			nack_reg      <= 1'b0;
		end else if (stop_det) begin
			state_reg     <= isaas_pkg::ST_IDLE;
			phase_reg     <= isaas_pkg::PH_ADDR;
			addr10_ok_reg <= 1'b0;
		end else if (start_det) begin
			// Repeated start keeps a finished ten-bit match for the read turn
			state_reg <= isaas_pkg::ST_RX;
			cnt_reg   <= isaas_pkg::CNT_ZERO;
			phase_reg <= isaas_pkg::PH_ADDR;
		end else begin
			case (state_reg)
				isaas_pkg::ST_RX: begin
					if (scl_rise && cnt_reg != isaas_pkg::BITS_PER_BYTE) begin
						shift_reg <= {shift_reg[6:0], sda_s2_reg};
						cnt_reg   <= cnt_reg + 4'h1;
					end
					if (rx_done) begin
						state_reg   <= isaas_pkg::ST_ACK;
						take_reg    <= take_now;
						ack_reg     <= ack_now;
						ua_pend_reg <= ua_now & ack_now;
						tx_pend_reg <= tx_now & ack_now;
						stay_reg    <= stay_now & (ack_now | ~is_addr_now);
						if (ack_now || !is_addr_now) begin
							phase_reg     <= phase_next;
							addr10_ok_reg <= addr10_now;
						end
					end
				end
				isaas_pkg::ST_ACK: begin
					if (scl_fall) begin
						cnt_reg <= isaas_pkg::CNT_ZERO;
						if (tx_pend_reg) begin
							state_reg <= isaas_pkg::ST_TX;
						end else if (stay_reg) begin
							state_reg <= isaas_pkg::ST_RX;
						end else begin
							state_reg <= isaas_pkg::ST_IDLE;
						end
					end
				end
				isaas_pkg::ST_TX: begin
					if (scl_fall) begin
						cnt_reg <= cnt_reg + 4'h1;
						if (cnt_reg == isaas_pkg::LAST_TX_CNT) begin
							state_reg <= isaas_pkg::ST_MACK;
						end
					end
				end
				isaas_pkg::ST_MACK: begin
					if (scl_rise) begin
						nack_reg <= sda_s2_reg;
					end
					if (scl_fall) begin
						cnt_reg   <= isaas_pkg::CNT_ZERO;
						state_reg <= nack_reg ? isaas_pkg::ST_IDLE : isaas_pkg::ST_TX;
					end
				end
				default: begin
					state_reg <= isaas_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// ==========================================================
	// Buffer and status flags; hardware set beats software clear
	always_ff @(posedge MCLK_I) begin
		if (!NRST_I) begin
			buf_reg <= isaas_pkg::BYTE_ZERO;
		end else if (rx_load) begin
			buf_reg <= shift_reg;
		end else if (BUF_WR_I) begin
			buf_reg <= BUF_WDATA_I;
		end
	end

	always_ff @(posedge MCLK_I) begin
		if (!NRST_I || !ENABLE_I) begin
			bf_reg <= 1'b0;
		end else if (rx_load || BUF_WR_I) begin
			bf_reg <= 1'b1;
		end else if (BUF_RD_I || tx_byte_end) begin
			bf_reg <= 1'b0;
		end
	end

	always_ff @(posedge MCLK_I) begin
		if (!NRST_I || !ENABLE_I) begin
			ovf_reg <= 1'b0;
		end else if (rx_done && take_now && bf_reg) begin
			ovf_reg <= 1'b1;
		end else if (OVF_CLR_I) begin
			ovf_reg <= 1'b0;
		end
	end

	always_ff @(posedge MCLK_I) begin
		if (!NRST_I || !ENABLE_I) begin
			irq_reg <= 1'b0;
		end else if ((ack_fall && take_reg) || mack_fall || (sp_irq && (start_det || stop_det))) begin
			irq_reg <= 1'b1;
		end else if (IRQ_CLR_I) begin
			irq_reg <= 1'b0;
		end
	end

	always_ff @(posedge MCLK_I) begin
		if (!NRST_I || !ENABLE_I) begin
			ua_reg <= 1'b0;
		end else if (ack_fall && ua_pend_reg) begin
			ua_reg <= 1'b1;
		end else if (ADDR_WR_I) begin
			ua_reg <= 1'b0;
		end
	end

	// Hardware clear wins so a late release cannot skip the stretch
	always_ff @(posedge MCLK_I) begin
		if (!NRST_I || !ENABLE_I) begin
			ckp_reg <= 1'b1;
		end else if ((ack_fall && tx_pend_reg) || (mack_fall && !nack_reg)) begin
			ckp_reg <= 1'b0;
		end else if (CKP_SET_I) begin
			ckp_reg <= 1'b1;
		end
	end

	always_ff @(posedge MCLK_I) begin
		if (!NRST_I || !ENABLE_I) begin
			rw_reg <= 1'b0;
			da_reg <= 1'b0;
		end else if (rx_done && take_now) begin
			da_reg <= ~is_addr_now;
			if (is_addr_now) begin
				rw_reg <= shift_reg[0];
			end
		end
	end

	always_ff @(posedge MCLK_I) begin
		if (!NRST_I || !ENABLE_I) begin
			start_reg <= 1'b0;
			stop_reg  <= 1'b0;
		end else if (start_det || stop_det) begin
			start_reg <= start_det;
			stop_reg  <= stop_det;
		end
	end

	// ==========================================================
	// Address and mask
	always_ff @(posedge MCLK_I) begin
		if (!NRST_I) begin
			addr_reg <= isaas_pkg::ADDR_RST;
		end else if (ADDR_WR_I) begin
			addr_reg <= ADDR_WDATA_I;
		end
	end

	always_ff @(posedge MCLK_I) begin
		if (!NRST_I) begin
			mask_reg     <= isaas_pkg::MASK_RST;
			mask_vis_reg <= isaas_pkg::BYTE_ZERO;
		end else begin
			if (MASK_WR_I && MODE_I == isaas_pkg::MODE_MASK_ACC) begin
				mask_reg <= MASK_WDATA_I;
			end
			mask_vis_reg <= (MODE_I == isaas_pkg::MODE_MASK_ACC) ? mask_reg : isaas_pkg::BYTE_ZERO;
		end
	end

	// ==========================================================
	// Open-drain drivers; enable low means pulling the line low
	always_ff @(posedge MCLK_I) begin
		if (!NRST_I) begin
			low_reg     <= 1'b0;
			scl_oen_reg <= 1'b1;
			sda_oen_reg <= 1'b1;
		end else begin
			low_reg     <= 1'b0;
			// Grab SCL only once seen low, never cutting a high phase short
			scl_oen_reg <= ~(ENABLE_I && (ua_reg || !ckp_reg)
				&& (!scl_oen_reg || !scl_s2_reg));
			sda_oen_reg <= ~((state_reg == isaas_pkg::ST_ACK && ack_reg)
				|| (state_reg == isaas_pkg::ST_TX
				&& !buf_reg[isaas_pkg::MSB_INDEX - cnt_reg[2:0]]));
		end
	end

	assign SCL_O           = low_reg;
	assign SDA_O           = low_reg;
	assign SCL_OEN_O       = scl_oen_reg;
	assign SDA_OEN_O       = sda_oen_reg;
	assign BUF_DATA_O      = buf_reg;
	assign BUF_FULL_O      = bf_reg;
	assign OVERFLOW_O      = ovf_reg;
	assign IRQ_FLAG_O      = irq_reg;
	assign ADDR_UPDATE_O   = ua_reg;
	assign READ_WRITE_O    = rw_reg;
	assign DATA_NOT_ADDR_O = da_reg;
	assign CLK_RELEASE_O   = ckp_reg;
	assign START_O         = start_reg;
	assign STOP_O          = stop_reg;
	assign SLAVE_ADDR_O    = addr_reg;
	assign ADDR_MASK_O     = mask_vis_reg;

	// ==========================================================
	// Checks
	default clocking cb @(posedge MCLK_I); endclocking
	default disable iff (!NRST_I);

	sequence s_acked_byte;
		rx_done && ack_now;
	endsequence
	property p_ack_load;
		s_acked_byte |=> BUF_FULL_O ##1 !SDA_OEN_O;
	endproperty
	a_ack_load: assert property (p_ack_load) else $error("ack or load missing");
	property p_no_load;
		(rx_done && (bf_reg || ovf_reg) && !BUF_WR_I) |=> $stable(buf_reg);
	endproperty
	a_no_load: assert property (p_no_load) else $error("buffer loaded while full");
	property p_rd_clear;
		(BUF_RD_I && !rx_load && !BUF_WR_I && ENABLE_I) |=> !BUF_FULL_O;
	endproperty
	a_rd_clear: assert property (p_rd_clear) else $error("read left full set");
	property p_ovf_set;
		(rx_done && take_now && bf_reg && ENABLE_I) |=> OVERFLOW_O;
	endproperty
	a_ovf_set: assert property (p_ovf_set) else $error("overflow not flagged");
	property p_irq_ninth;
		(ack_fall && take_reg && ENABLE_I) |=> IRQ_FLAG_O;
	endproperty
	a_irq_ninth: assert property (p_irq_ninth) else $error("irq missing at ninth fall");
	property p_ua_clear;
		(ADDR_WR_I && !(ack_fall && ua_pend_reg)) |=> !ADDR_UPDATE_O;
	endproperty
	a_ua_clear: assert property (p_ua_clear) else $error("update flag not cleared");
	property p_scl_grab;
		$fell(SCL_OEN_O) |-> !$past(scl_s2_reg);
	endproperty
	a_scl_grab: assert property (p_scl_grab) else $error("SCL pulled while high");
	property p_hold;
		(ENABLE_I && !CLK_RELEASE_O && !scl_s2_reg) |=> !SCL_OEN_O;
	endproperty
	a_hold: assert property (p_hold) else $error("SCL not stretched");
	property p_tx_bf;
		(tx_byte_end && !BUF_WR_I && ENABLE_I) |=> !BUF_FULL_O ##1 SDA_OEN_O;
	endproperty
	a_tx_bf: assert property (p_tx_bf) else $error("transmit end wrong");
	property p_mask_lock;
		(MASK_WR_I && MODE_I != isaas_pkg::MODE_MASK_ACC) |=> $stable(mask_reg);
	endproperty
	a_mask_lock: assert property (p_mask_lock) else $error("mask written outside mode");

endmodule

//--- test/isaas_master.sv
`timescale 1ns/1ps
module isaas_master (
	// Clock
	input  wire logic clk_i,
	// Resolved bus lines
	input  wire logic scl_i,
	input  wire logic sda_i,
	// Open-drain pull-downs
	output logic      scl_low_o,
	output logic      sda_low_o,
	// Stall watchdog
	output int        hang_o
);
	initial begin
		scl_low_o = 1'b0;
		sda_low_o = 1'b0;
		hang_o = 0;
	end

	// ==========================================================
	// Half period of the link clock
	task automatic half();
		repeat (4) @(posedge clk_i);
	endtask

	// Release SCL; a slave may still hold it, so wait it out
	task automatic rise();
		int n;
		n = 0;
		scl_low_o <= 1'b0;
		@(posedge clk_i);
		while (scl_i !== 1'b1 && n < 3000) begin
			@(posedge clk_i);
			n++;
		end
		if (n >= 3000) hang_o <= hang_o + 1;
		half();
	endtask

	// ==========================================================
	// Bit, start, stop; data bits move SDA only while SCL is low, start and stop move it while SCL is high
	task automatic bit_x(input logic b, output logic r);
		sda_low_o <= !b;
		half();
		rise();
		r = sda_i;
		scl_low_o <= 1'b1;
		half();
	endtask

	task automatic start();
		sda_low_o <= 1'b0;
		half();
		rise();
		sda_low_o <= 1'b1;
		half();
		scl_low_o <= 1'b1;
		half();
	endtask

	task automatic stop();
		sda_low_o <= 1'b1;
		half();
		rise();
		sda_low_o <= 1'b0;
		half();
	endtask

	// ==========================================================
	// Bytes, MSB first, ninth bit is the acknowledge
	task automatic write_byte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bit_x(d[i], r);
		bit_x(1'b1, r);
		ack = !r;
	endtask

	task automatic read_byte(input logic ack_i, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_x(1'b1, r);
			d[i] = r;
		end
		bit_x(!ack_i, r);
	endtask
endmodule

//--- test/isaas_top_test.sv
`timescale 1ns/1ps
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin fail_count++; \
	$display("[ERR] %0t got %h expected %h", $time, (got), (exp)); end end
module isaas_top_test;
	localparam int OP_ADR = 0, OP_MSK = 1, OP_RD = 2, OP_WR = 3, OP_OVF = 4, OP_IRQ = 5;
	localparam int OP_CKP = 6;
	logic       mclk, rst_n, en, m_scl, m_sda, ack, full, ovf, irq, upd, rw, dna, rel;
	logic       scl_oen, sda_oen, st, sp, scl_o, sda_o;
	logic [6:0] stb;
	logic [3:0] mode;
	logic [7:0] dat, d, buf_d, slv_adr, mask;
	wire logic  scl, sda;
	int         hang, fail_count, n_checks, cyc;

	// ==========================================================
	// Pull-ups on both lines
	assign scl = !m_scl && (scl_oen || scl_o);
	assign sda = !m_sda && (sda_oen || sda_o);

	isaas_top isaas_top_i (.MCLK_I(mclk), .NRST_I(rst_n), .SCL_I(scl), .SCL_O(scl_o),
		.SCL_OEN_O(scl_oen), .SDA_I(sda), .SDA_O(sda_o), .SDA_OEN_O(sda_oen), .ENABLE_I(en),
		.MODE_I(mode), .ADDR_WR_I(stb[0]), .ADDR_WDATA_I(dat), .MASK_WR_I(stb[1]),
		.MASK_WDATA_I(dat), .BUF_RD_I(stb[2]), .BUF_WR_I(stb[3]), .BUF_WDATA_I(dat),
		.OVF_CLR_I(stb[4]), .IRQ_CLR_I(stb[5]), .CKP_SET_I(stb[6]), .BUF_DATA_O(buf_d),
		.BUF_FULL_O(full), .OVERFLOW_O(ovf), .IRQ_FLAG_O(irq), .ADDR_UPDATE_O(upd),
		.READ_WRITE_O(rw), .DATA_NOT_ADDR_O(dna), .CLK_RELEASE_O(rel), .START_O(st),
		.STOP_O(sp), .SLAVE_ADDR_O(slv_adr), .ADDR_MASK_O(mask));

	isaas_master m (.clk_i(mclk), .scl_i(scl), .sda_i(sda), .scl_low_o(m_scl),
		.sda_low_o(m_sda), .hang_o(hang));

	always #20 mclk = ~mclk;

	// ==========================================================
	// Software side: one-cycle strobes
	task automatic sw(input int op, input logic [7:0] v);
		@(posedge mclk);
		stb[op] <= 1'b1;
		dat <= v;
		@(posedge mclk);
		stb <= 7'h00;
		repeat (2) @(negedge mclk);
	endtask

	task automatic set_mode(input logic [3:0] md);
		@(posedge mclk);
		mode <= md;
		repeat (2) @(negedge mclk);
	endtask

	task automatic settle();
		repeat (6) @(negedge mclk);
	endtask

	task automatic test_end(input string name);
		$display("test %s done", name);
	endtask

	task automatic test_done();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// Whole run is a few thousand cycles
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 30000) begin
			fail_count++;
			test_done();
		end
	end

	// ==========================================================
	// Tests
	initial begin
		mclk = 1'b0;
		rst_n = 1'b0;
		en = 1'b0;
		mode = isaas_pkg::MODE_SLAVE7;
		stb = 7'h00;
		dat = 8'h00;
		fail_count = 0;
		n_checks = 0;
		cyc = 0;
		repeat (12) @(posedge mclk);
		rst_n <= 1'b1;
		en <= 1'b1;
		repeat (4) @(negedge mclk);
		`CHK({rel, full, ovf, irq, upd}, 5'h10)
		`CHK({scl_oen, sda_oen, scl_o, sda_o}, 4'hc)
		sw(OP_MSK, 8'h00);
		set_mode(isaas_pkg::MODE_MASK_ACC);
		`CHK(mask, 8'hff)
		sw(OP_MSK, 8'hfd);
		`CHK(mask, 8'hfd)
		set_mode(isaas_pkg::MODE_SLAVE7);
		sw(OP_ADR, 8'ha4);
		`CHK(slv_adr, 8'ha4)
		test_end("reset_mask");

		m.start();
		m.write_byte(8'ha6, ack);
		settle();
		`CHK({ack, buf_d, full, irq, rw, dna}, {1'b1, 8'ha6, 4'hc})
		`CHK({st, sp}, 2'h2)
		sw(OP_RD, 8'h00);
		sw(OP_IRQ, 8'h00);
		m.write_byte(8'h3c, ack);
		settle();
		`CHK({ack, buf_d, full, irq, dna}, {1'b1, 8'h3c, 3'h7})
		sw(OP_IRQ, 8'h00);
		m.write_byte(8'h55, ack);
		settle();
		`CHK({ack, buf_d, ovf, irq}, {1'b0, 8'h3c, 2'h3})
		sw(OP_RD, 8'h00);
		sw(OP_IRQ, 8'h00);
		`CHK({full, ovf}, 2'h1)
		m.write_byte(8'h66, ack);
		settle();
		`CHK({ack, buf_d, irq}, {1'b0, 8'h3c, 1'b1})
		sw(OP_OVF, 8'h00);
		sw(OP_IRQ, 8'h00);
		m.write_byte(8'h77, ack);
		settle();
		`CHK({ack, buf_d, ovf}, {1'b1, 8'h77, 1'b0})
		m.stop();
		settle();
		`CHK(sp, 1'b1)
		sw(OP_RD, 8'h00);
		set_mode(isaas_pkg::MODE_MASK_ACC);
		sw(OP_MSK, 8'hff);
		set_mode(isaas_pkg::MODE_SLAVE7);
		m.start();
		m.write_byte(8'ha6, ack);
		m.stop();
		settle();
		`CHK({ack, full}, 2'h0)
		test_end("write7");

		sw(OP_IRQ, 8'h00);
		m.start();
		m.write_byte(8'ha5, ack);
		settle();
		`CHK({ack, rw, full, rel, scl_oen, buf_d}, {5'h1c, 8'ha5})
		sw(OP_RD, 8'h00);
		sw(OP_IRQ, 8'h00);
		sw(OP_WR, 8'hc3);
		`CHK({full, scl_oen, scl}, 3'h4)
		sw(OP_CKP, 8'h00);
		m.read_byte(1'b1, d);
		settle();
		`CHK({d, full, irq, rel}, {8'hc3, 3'h2})
		sw(OP_IRQ, 8'h00);
		sw(OP_WR, 8'h5a);
		sw(OP_CKP, 8'h00);
		m.read_byte(1'b0, d);
		settle();
		`CHK({d, full, rel, sda_oen}, {8'h5a, 3'h3})
		m.stop();
		test_end("read7");

		sw(OP_IRQ, 8'h00);
		set_mode(isaas_pkg::MODE_SLAVE10);
		sw(OP_ADR, 8'hf4);
		m.start();
		m.write_byte(8'hf4, ack);
		settle();
		`CHK({ack, upd, irq, full, scl_oen}, 5'h1e)
		sw(OP_RD, 8'h00);
		sw(OP_IRQ, 8'h00);
		sw(OP_ADR, 8'hc5);
		`CHK({upd, scl_oen}, 2'h1)
		m.write_byte(8'hc5, ack);
		settle();
		`CHK({ack, upd, irq, full, scl_oen}, 5'h1e)
		sw(OP_ADR, 8'hf4);
		sw(OP_RD, 8'h00);
		sw(OP_IRQ, 8'h00);
		m.write_byte(8'h99, ack);
		settle();
		`CHK({ack, buf_d, dna}, {1'b1, 8'h99, 1'b1})
		sw(OP_RD, 8'h00);
		sw(OP_IRQ, 8'h00);
		m.start();
		m.write_byte(8'hf5, ack);
		settle();
		`CHK({ack, full, rel, scl_oen}, 4'hc)
		sw(OP_RD, 8'h00);
		sw(OP_IRQ, 8'h00);
		sw(OP_ADR, 8'hf4);
		sw(OP_WR, 8'h81);
		sw(OP_CKP, 8'h00);
		m.read_byte(1'b0, d);
		m.stop();
		settle();
		`CHK(d, 8'h81)
		test_end("addr10");

		sw(OP_IRQ, 8'h00);
		set_mode(isaas_pkg::MODE_SLAVE7_SP);
		m.start();
		settle();
		`CHK({irq, st, sp}, 3'h6)
		sw(OP_IRQ, 8'h00);
		set_mode(isaas_pkg::MODE_SLAVE10_SP);
		m.stop();
		settle();
		`CHK({irq, st, sp}, 3'h5)
		test_end("start_stop_irq");

		sw(OP_IRQ, 8'h00);
		set_mode(isaas_pkg::MODE_FW_MASTER);
		m.start();
		m.write_byte(8'ha4, ack);
		m.stop();
		settle();
		`CHK({ack, irq, buf_d}, {2'h1, 8'h81})
		`CHK(hang, 0)
		test_end("fw_master");

		// Disable clears irq, start and stop, sets release, but keeps the address
		@(posedge mclk);
		en <= 1'b0;
		repeat (2) @(negedge mclk);
		`CHK({irq, rel, st, sp, slv_adr}, {4'h4, 8'hf4})
		test_end("disable");
		test_done();
	end
endmodule
